//--- logic/lpc_regs.v
`timescale 1ns/1ps
`include "lpc_defines.vh"
// Overview of operation
// - wake settle code picks settle wait, reset 1
// - triggered select 0: sleep time from interval
// - triggered select 1: wake while trigger low
// - low-power enable resets 0, needs background enable
// - vector port works only with enable bit 0
// - gain adjust 8-bit read/write, factory reset value
// - sleep interval code picks autonomous sleep time
// - source select chooses software bit or pin
module lpc_regs #(
  parameter TW = 42,
  parameter [TW-1:0] WAKE_CYC0 = (42'h1 << 3) + 42'h1,
  parameter [TW-1:0] WAKE_CYC1 = (42'h1 << 18) + 42'h1,
  parameter [TW-1:0] WAKE_CYC2 = (42'h1 << 21) + 42'h1,
  parameter [TW-1:0] WAKE_CYC3 = (42'h1 << 24) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC0 = (42'h1 << 3) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC1 = (42'h1 << 15) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC2 = (42'h1 << 18) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC3 = (42'h1 << 21) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC4 = (42'h1 << 24) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC5 = (42'h1 << 27) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC6 = (42'h1 << 30) + 42'h1,
  parameter [TW-1:0] SLEEP_CYC7 = (42'h1 << 33) + 42'h1,
  parameter [TW-1:0] DELAY_UNIT = `LPC_DELAY_UNIT,
  parameter [7:0] GAIN_A_TRIM = 8'h80, // factory trim, arbitrary default
  parameter [7:0] GAIN_B_TRIM = 8'h80, // factory trim, arbitrary default
  parameter VEC_LEN = `LPC_VEC_LEN
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst,
  // register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_write,
  input wire i_read,
  output reg [7:0] o_rdata,
  // calibration engine side
  input wire i_background_cal_enable,
  input wire i_cal_halted,
  input wire i_cal_done,
  input wire i_cal_trigger_input,
  output reg o_core_sleep,
  output reg o_cal_start,
  output reg o_vector_valid,
  // gain trims
  output reg [7:0] o_gain_a,
  output reg [7:0] o_gain_b
);
  // ----------------------------------------------------------------------
  // scheduler states
  // ----------------------------------------------------------------------
  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_SLEEP = 4'h2;
  localparam [3:0] ST_SETTLE = 4'h4;
  localparam [3:0] ST_CAL = 4'h8;

  reg [7:0] lp_cfg;
  reg [7:0] vec_en_reg;
  reg trigger_source_select;
  reg software_cal_trigger;
  reg [7:0] vec_mem [0:VEC_LEN-1];
  reg [9:0] vec_index;
  reg vec_busy;
  reg vec_en_d;
  reg trig_meta;
  reg trig_sync;
  reg [3:0] state;
  reg [3:0] next_state;
  reg timer_load;
  reg [TW-1:0] timer_count;
  wire timer_done;
  wire low_power_cal_enable;
  wire triggered_wake_select;
  wire [1:0] wake_settle_delay;
  wire [2:0] sleep_interval;
  wire lp_active;
  wire cal_trigger;
  wire vec_access_en;
  wire vec_hit;
  wire vec_last;

  // decoded configuration fields
  assign low_power_cal_enable = lp_cfg[`LPC_LOW_POWER_CAL_ENABLE_BIT];
  assign triggered_wake_select = lp_cfg[`LPC_TRIGGERED_WAKE_SELECT_BIT];
  assign wake_settle_delay = lp_cfg[`LPC_WAKE_MSB:`LPC_WAKE_LSB];
  assign sleep_interval = lp_cfg[`LPC_SLEEP_MSB:`LPC_SLEEP_LSB];
  assign lp_active = low_power_cal_enable & i_background_cal_enable;
  assign cal_trigger = trigger_source_select ? trig_sync : software_cal_trigger;
  assign vec_access_en = vec_en_reg[`LPC_VEC_EN_BIT];
  assign vec_hit = vec_access_en && (i_addr == `LPC_ADDR_VEC_PORT) && (i_read || i_write);
  assign vec_last = (vec_index == VEC_LEN - 1);

  // ----------------------------------------------------------------------
  // delay tables
  // ----------------------------------------------------------------------
  function [TW-1:0] wake_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0: wake_cycles = WAKE_CYC0 * DELAY_UNIT;
        2'h1: wake_cycles = WAKE_CYC1 * DELAY_UNIT;
        2'h2: wake_cycles = WAKE_CYC2 * DELAY_UNIT;
        default: wake_cycles = WAKE_CYC3 * DELAY_UNIT;
      endcase
    end
  endfunction

  function [TW-1:0] sleep_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h0: sleep_cycles = SLEEP_CYC0 * DELAY_UNIT;
        3'h1: sleep_cycles = SLEEP_CYC1 * DELAY_UNIT;
        3'h2: sleep_cycles = SLEEP_CYC2 * DELAY_UNIT;
        3'h3: sleep_cycles = SLEEP_CYC3 * DELAY_UNIT;
        3'h4: sleep_cycles = SLEEP_CYC4 * DELAY_UNIT;
        3'h5: sleep_cycles = SLEEP_CYC5 * DELAY_UNIT;
        3'h6: sleep_cycles = SLEEP_CYC6 * DELAY_UNIT;
        default: sleep_cycles = SLEEP_CYC7 * DELAY_UNIT;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // trigger pin synchroniser
  // ----------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      trig_meta <= 1'b1;
      trig_sync <= 1'b1;
    end else begin
      trig_meta <= i_cal_trigger_input;
      trig_sync <= trig_meta;
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      lp_cfg <= `LPC_RST_LP_CFG;
      vec_en_reg <= `LPC_RST_VEC_EN;
      trigger_source_select <= `LPC_RST_TRIG_SRC;
      software_cal_trigger <= `LPC_RST_SOFT_TRIG;
      o_gain_a <= GAIN_A_TRIM;
      o_gain_b <= GAIN_B_TRIM;
    end else if (i_write) begin
      case (i_addr)
        `LPC_ADDR_LP_CFG: lp_cfg <= i_wdata;
        `LPC_ADDR_VEC_EN: vec_en_reg <= i_wdata;
        `LPC_ADDR_TRIG_SRC: trigger_source_select <= i_wdata[`LPC_TRIG_SRC_BIT];
        `LPC_ADDR_SOFT_TRIG: software_cal_trigger <= i_wdata[`LPC_SOFT_TRIG_BIT];
        `LPC_ADDR_GAIN_A: o_gain_a <= i_wdata;
        `LPC_ADDR_GAIN_B: o_gain_b <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // calibration vector port
  // ----------------------------------------------------------------------
  // the array is not reset: it holds whatever was last written through the vector port
  always @(posedge i_clock) begin
    if (vec_hit && i_write) begin
      vec_mem[vec_index] <= i_wdata;
    end
  end

  // index walk and validity; the engine must be halted, which is left to software
  always @(posedge i_clock) begin
    if (i_rst) begin
      vec_index <= 10'h000;
      vec_busy <= 1'b0;
      vec_en_d <= 1'b0;
      o_vector_valid <= 1'b1;
    end else begin
      vec_en_d <= vec_access_en;
      if (vec_access_en && !vec_en_d) begin
        vec_index <= 10'h000;
        vec_busy <= 1'b0;
      end else if (vec_hit) begin
        vec_index <= vec_last ? 10'h000 : vec_index + 10'h001;
        vec_busy <= !vec_last;
        o_vector_valid <= vec_last;
      end else if (!vec_access_en && vec_busy) begin
        vec_busy <= 1'b0; // an abandoned sequence stays invalid
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_read) begin
      case (i_addr)
        `LPC_ADDR_LP_CFG: o_rdata <= lp_cfg;
        `LPC_ADDR_VEC_EN: o_rdata <= vec_en_reg;
        `LPC_ADDR_VEC_PORT: o_rdata <= vec_access_en ? vec_mem[vec_index] : 8'h00;
        `LPC_ADDR_TRIG_SRC: o_rdata <= {7'h00, trigger_source_select};
        `LPC_ADDR_SOFT_TRIG: o_rdata <= {7'h00, software_cal_trigger};
        `LPC_ADDR_STATUS: o_rdata <= {o_vector_valid, i_cal_halted, vec_busy, 1'b0, state};
        `LPC_ADDR_GAIN_A: o_rdata <= o_gain_a;
        `LPC_ADDR_GAIN_B: o_rdata <= o_gain_b;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // low-power scheduler
  // ----------------------------------------------------------------------
  // next state and timer load, decided from the current state
  always @* begin
    next_state = state;
    timer_load = 1'b0;
    timer_count = wake_cycles(wake_settle_delay);
    case (state)
      ST_OFF: begin
        if (lp_active) begin
          next_state = ST_SLEEP;
          timer_load = !triggered_wake_select;
          timer_count = sleep_cycles(sleep_interval);
        end
      end
      ST_SLEEP: begin
        if (triggered_wake_select ? !cal_trigger : timer_done) begin
          next_state = ST_SETTLE;
          timer_load = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (timer_done) begin
          next_state = ST_CAL;
        end
      end
      ST_CAL: begin
        if (i_cal_done) begin
          next_state = ST_SLEEP;
          timer_load = !triggered_wake_select;
          timer_count = sleep_cycles(sleep_interval);
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (!lp_active) begin
      next_state = ST_OFF;
      timer_load = 1'b0;
    end
  end

  // state register and core controls
  always @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_OFF;
      o_core_sleep <= 1'b0;
      o_cal_start <= 1'b0;
    end else begin
      state <= next_state;
      o_core_sleep <= (next_state == ST_SLEEP);
      o_cal_start <= (state == ST_SETTLE) && (next_state == ST_CAL);
    end
  end

  // settle and sleep waits share one counter since they never overlap
  lpc_delay_timer #(
    .WIDTH(TW)
  ) u_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(timer_load),
    .i_abort(!lp_active),
    .i_count(timer_count),
    .o_done(timer_done)
  );
endmodule

//--- logic/lpc_defines.vh
`ifndef LPC_DEFINES_VH
`define LPC_DEFINES_VH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LPC_ADDR_TRIG_SRC 8'h6b
`define LPC_ADDR_SOFT_TRIG 8'h6c
`define LPC_ADDR_STATUS 8'h6d
`define LPC_ADDR_LP_CFG 8'h6e
`define LPC_ADDR_VEC_EN 8'h70
`define LPC_ADDR_VEC_PORT 8'h71
`define LPC_ADDR_GAIN_A 8'h7a
`define LPC_ADDR_GAIN_B 8'h7b
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LPC_LOW_POWER_CAL_ENABLE_BIT 0
`define LPC_TRIGGERED_WAKE_SELECT_BIT 1
`define LPC_WAKE_LSB 3
`define LPC_WAKE_MSB 4
`define LPC_SLEEP_LSB 5
`define LPC_SLEEP_MSB 7
`define LPC_VEC_EN_BIT 0
`define LPC_TRIG_SRC_BIT 0
`define LPC_SOFT_TRIG_BIT 0
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LPC_RST_LP_CFG 8'h48
`define LPC_RST_VEC_EN 8'h00
`define LPC_RST_TRIG_SRC 1'h0
`define LPC_RST_SOFT_TRIG 1'h1
// ----------------------------------------------------------------------
// timing: delays in device clock periods, (2^e + 1) * 256
// ----------------------------------------------------------------------
`define LPC_DELAY_UNIT 256
`define LPC_VEC_LEN 673
`endif

//--- logic/lpc_delay_timer.v
`timescale 1ns/1ps
`include "lpc_defines.vh"
module lpc_delay_timer #(
  parameter WIDTH = 42
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst,
  // control
  input wire i_load,
  input wire i_abort,
  input wire [WIDTH-1:0] i_count,
  // status
  output reg o_done
);
  reg [WIDTH-1:0] remaining;
  reg running;

  // ----------------------------------------------------------------------
  // down counter, one done pulse after the loaded number of cycles
  // ----------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      remaining <= {WIDTH{1'b0}};
      running <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        running <= 1'b0;
      end else if (i_load) begin
        // a zero count still waits one cycle
        remaining <= (i_count == {WIDTH{1'b0}}) ? {WIDTH{1'b0}} : i_count - 1'b1;
        running <= 1'b1;
      end else if (running) begin
        if (remaining == {WIDTH{1'b0}}) begin
          running <= 1'b0;
          o_done <= 1'b1;
        end else begin
          remaining <= remaining - 1'b1;
        end
      end
    end
  end
endmodule

//--- bench/lpc_regs_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks for the calibration register bank
// ----------------------------------------------------------------
module lpc_regs_chk (
  input logic i_clock, i_rst, i_write, i_read, i_background_cal_enable,
  input logic i_cal_halted, i_cal_done, i_cal_trigger_input,
  input logic [7:0] i_addr, i_wdata, o_rdata, o_gain_a, o_gain_b,
  input logic o_core_sleep, o_cal_start, o_vector_valid
);
  logic vec_hit;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // access to the vector port in this cycle
  assign vec_hit = (i_read || i_write) && i_addr == 8'h71;
  // a woken core waits out the settle time before calibration starts
  sequence s_wake;
    $fell(o_core_sleep) && i_background_cal_enable;
  endsequence
  sequence s_settle;
    (!o_cal_start)[*4] ##[1:40] o_cal_start;
  endsequence
  property p_rd_idle; !i_read |=> o_rdata == 8'h00; endproperty
  property p_unmapped; i_read && i_addr == 8'h00 |=> o_rdata == 8'h00; endproperty
  property p_gain_wr; i_write && i_addr == 8'h7a |=> o_gain_a == $past(i_wdata); endproperty
  property p_gain_keep; !(i_write && i_addr == 8'h7a) |=> $stable(o_gain_a); endproperty
  property p_gain_rd; i_read && i_addr == 8'h7b |=> o_rdata == $past(o_gain_b); endproperty
  property p_lp_off; !i_background_cal_enable |=> !o_core_sleep; endproperty
  property p_start_pulse; o_cal_start |=> !o_cal_start; endproperty
  property p_settle; s_wake |-> s_settle; endproperty
  property p_vec_fall; $fell(o_vector_valid) |-> $past(vec_hit) || $past(vec_hit, 2); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_gain_wr: assert property (p_gain_wr) else $error("gain a not written");
  a_gain_keep: assert property (p_gain_keep) else $error("gain a changed");
  a_gain_rd: assert property (p_gain_rd) else $error("gain b readback wrong");
  a_lp_off: assert property (p_lp_off) else $error("sleep without background");
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  a_settle: assert property (p_settle) else $error("settle time wrong");
  a_vec_fall: assert property (p_vec_fall) else $error("valid lost w/o access");
endmodule
bind lpc_regs lpc_regs_chk i_lpc_regs_chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_write(i_write), .i_read(i_read), .i_background_cal_enable(i_background_cal_enable),
  .i_cal_halted(i_cal_halted), .i_cal_done(i_cal_done), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_cal_trigger_input(i_cal_trigger_input), .o_rdata(o_rdata), .o_gain_a(o_gain_a),
  .o_gain_b(o_gain_b), .o_core_sleep(o_core_sleep), .o_cal_start(o_cal_start),
  .o_vector_valid(o_vector_valid));

//--- bench/lpc_cal_engine_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// calibration engine stand-in
// ----------------------------------------------------------------
module lpc_cal_engine_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_cal_start,
  output logic o_cal_halted,
  output logic o_cal_done
);
  logic [2:0] busy_cnt;
  // a run lasts a few cycles, slow or prompt, then reports done
  always @(posedge i_clock) begin
    if (i_rst) busy_cnt <= 3'h0;
    else if (i_cal_start) busy_cnt <= i_slow ? 3'h7 : 3'h2;
    else if (busy_cnt != 3'h0) busy_cnt <= busy_cnt - 3'h1;
  end
  // halted only when idle, so vector traffic is safe then
  assign o_cal_halted = (busy_cnt == 3'h0);
  assign o_cal_done = (busy_cnt == 3'h1);
endmodule

//--- bench/test_lpc_regs.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench for the calibration register bank
// ----------------------------------------------------------------
module test_lpc_regs;
  logic i_clock = 1'b0, i_rst = 1'b1, i_write = 1'b0, i_read = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic bg_en = 1'b0, trig_pin = 1'b1, slow = 1'b0;
  wire [7:0] o_rdata, o_gain_a, o_gain_b;
  wire o_core_sleep, o_cal_start, o_vector_valid, halted, done;
  integer failures = 0, num_checks = 0, n, m, k, c;
  initial begin
    forever #20 i_clock = ~i_clock;
  end
  // one unit per cycle: code 0 keeps its nine-cycle length, wake codes 1-3 become
  // 11/13/15 and sleep code 1 becomes 12; longer sleep codes would not fit the run
  lpc_regs #(.DELAY_UNIT(42'd1), .WAKE_CYC1(42'd11), .WAKE_CYC2(42'd13), .WAKE_CYC3(42'd15),
    .SLEEP_CYC1(42'd12)) i_lpc_regs (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_background_cal_enable(bg_en), .i_cal_halted(halted), .i_cal_done(done),
    .i_cal_trigger_input(trig_pin), .o_core_sleep(o_core_sleep), .o_cal_start(o_cal_start),
    .o_vector_valid(o_vector_valid), .o_gain_a(o_gain_a), .o_gain_b(o_gain_b));
  lpc_cal_engine_model i_lpc_cal_engine_model (.i_clock(i_clock), .i_rst(i_rst),
    .i_slow(slow), .i_cal_start(o_cal_start), .o_cal_halted(halted), .o_cal_done(done));
  task chk(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // idle cycle after each access keeps every strobe to one assignment per step
  task wr(input [7:0] a, input [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
    @(posedge i_clock);
  endtask
  // read data stand for one cycle only, so they are looked at mid-cycle
  task rd(input [7:0] a, input [7:0] exp);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(negedge i_clock);
    chk(o_rdata, exp);
    @(posedge i_clock);
  endtask
  // samples on the falling edge, where outputs launched at the rising edge have settled
  task wait_sleep(input v, output integer cnt);
    cnt = 0;
    @(negedge i_clock);
    while (o_core_sleep !== v && cnt < 2000) begin
      @(negedge i_clock);
      cnt = cnt + 1;
    end
    @(posedge i_clock);
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    #(40 * 60000);
    failures = failures + 1;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(8'h6e, 8'h48);
    rd(8'h70, 8'h00);
    rd(8'h6b, 8'h00);
    rd(8'h6c, 8'h01);
    rd(8'h00, 8'h00);
    rd(8'h71, 8'h00);
    rd(8'h6d, 8'hc1);
    chk(o_gain_a, 8'h80);
    wr(8'h7a, 8'h12);
    wr(8'h7b, 8'hed);
    chk(o_gain_a, 8'h12);
    rd(8'h7b, 8'hed);
    wr(8'h71, 8'h33);
    chk(o_vector_valid, 1'b1);
    // store a whole vector, then read it back from element zero
    chk(halted, 1'b1);
    wr(8'h70, 8'h01);
    // streamed: strobe held high with new data every cycle
    i_addr <= 8'h71;
    i_write <= 1'b1;
    for (k = 0; k < 673; k = k + 1) begin
      if (k == 2) chk(o_vector_valid, 1'b0);
      i_wdata <= k[7:0] ^ k[9:2];
      @(posedge i_clock);
    end
    i_write <= 1'b0;
    @(posedge i_clock);
    chk(o_vector_valid, 1'b1);
    wr(8'h70, 8'h00);
    wr(8'h70, 8'h01);
    for (k = 0; k < 673; k = k + 1) rd(8'h71, k[7:0] ^ k[9:2]);
    // an abandoned sequence must leave the vector marked invalid
    wr(8'h70, 8'h00);
    wr(8'h70, 8'h01);
    for (k = 0; k < 10; k = k + 1) rd(8'h71, k[7:0] ^ k[9:2]);
    wr(8'h70, 8'h00);
    @(posedge i_clock);
    chk(o_vector_valid, 1'b0);
    // a fresh enable restarts at element zero, not at element ten
    wr(8'h70, 8'h01);
    rd(8'h71, 8'h00);
    rd(8'h71, 8'h01);
    // autonomous sleep and settle lengths: sleep codes 0 and 1, every wake code
    for (c = 0; c < 8; c = c + 1) begin
      bg_en <= 1'b0;
      slow <= c[2];
      wr(8'h6e, {2'b00, c[0], c[1:0], 3'b001});
      bg_en <= 1'b1;
      wait_sleep(1'b1, n);
      chk(n <= 2, 1'b1);
      wait_sleep(1'b0, n);
      chk(n >= 9 + 3 * c[0] && n <= 12 + 3 * c[0], 1'b1);
      m = 0;
      @(negedge i_clock);
      while (o_cal_start !== 1'b1 && m < 200) begin
        @(negedge i_clock);
        m = m + 1;
      end
      @(posedge i_clock);
      chk(m >= 9 + 2 * c[1:0] && m <= 12 + 2 * c[1:0], 1'b1);
    end
    // triggered wake: only the selected source can wake the core
    bg_en <= 1'b0;
    trig_pin <= 1'b0;
    wr(8'h6e, 8'h0b); // wake code 1, the lowest advised
    repeat (4) @(posedge i_clock);
    chk(o_core_sleep, 1'b0);
    bg_en <= 1'b1;
    repeat (40) @(posedge i_clock);
    chk(o_core_sleep, 1'b1);
    wr(8'h6c, 8'h00);
    wait_sleep(1'b0, n);
    chk(n < 12, 1'b1);
    trig_pin <= 1'b1;
    wr(8'h6b, 8'h01);
    repeat (60) @(posedge i_clock);
    chk(o_core_sleep, 1'b1);
    trig_pin <= 1'b0;
    wait_sleep(1'b0, n);
    chk(n < 12, 1'b1);
    wrap_up;
  end
endmodule
